//--- src/fls_pwr_pkg.sv
// Shared constants, carrier structs and state codes for the flash power-saving control
package fls_pwr_pkg;

    // Clock and timing figures as printed, cycle counts derived from them
    localparam int CLK_PERIOD_NS  = 25;
    localparam int ENTRY_MIN_US   = 10;
    localparam int WAKE_MAX_US    = 300;
    localparam int ACCESS_MAX_NS  = 96;
    localparam int STOP_EXTRA_NS  = 30;
    localparam int RST_PULSE_NS   = 200;

    // Least times round up, longest times round down
    localparam int ENTRY_CYC = (ENTRY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC  = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int STOP_CYC  = (ACCESS_MAX_NS + STOP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Configuration word layout and power-on default
    localparam int          CFG_W        = 16;
    localparam int          SLEEP_BIT    = 15;
    localparam logic [15:0] CFG_DEFAULT  = 16'hFFFF;
    localparam int          DQ_W         = 8;

    // Bus pins, all from outside the clock domain
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic hw_rst_n;
    } pins_t;

    // Decoded commands from the bus front end, same clock domain
    typedef struct packed {
        logic              cfg_write;
        logic              sleep_cmd;
        logic [CFG_W-1:0]  cfg_data;
    } cmd_t;

    // Data phase of the current transfer, same clock domain
    typedef struct packed {
        logic             xfer_active;
        logic             read_valid;
        logic [DQ_W-1:0]  read_data;
    } xfer_t;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_ENTRY   = 4'h2,
        ST_SLEEP   = 4'h4,
        ST_WAKE    = 4'h8
    } pwr_state_t;

endpackage

//--- src/fls_interval_timer.sv
// Down-counting interval timer with a loadable interval length
`timescale 1ns/1ps
module fls_interval_timer #(
    parameter int W = 14
) (
    input  wire logic         ref_clk,   // System clock
    input  wire logic         reset_n,   // Synchronous reset, active low
    input  wire logic         start,     // Load and run, one-cycle pulse
    input  wire logic         cancel,    // Stop without done
    input  wire logic [W-1:0] length,    // Interval in cycles, at least one
    output logic              busy,      // Interval running
    output logic              done       // Last cycle of the interval
);
    logic [W-1:0] cnt_r;
    logic         busy_r;

    assign busy = busy_r;
    assign done = busy_r && (cnt_r == '0) && !start;

    // Start wins over cancel so a restart is never lost
    always_ff @(posedge ref_clk) begin
        if (!reset_n || (cancel && !start) || done) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r  <= length - W'(1);
        end else if (busy_r) begin
            cnt_r  <= cnt_r - W'(1);
        end
    end
endmodule

//--- src/fls_pwr_ctrl.sv
// Deep sleep sequencing and active clock stop for the flash bus interface
`timescale 1ns/1ps
module fls_pwr_ctrl
    import fls_pwr_pkg::*;
#(
    parameter int ENTRY_CYCLES = fls_pwr_pkg::ENTRY_CYC,  // Entry window in cycles
    parameter int WAKE_CYCLES  = fls_pwr_pkg::WAKE_CYC,   // Wake-up interval in cycles
    parameter int STOP_CYCLES  = fls_pwr_pkg::STOP_CYC,   // Still-clock time before stop
    parameter int RST_CYCLES   = fls_pwr_pkg::RST_CYC     // Least valid reset pulse
) (
    input  wire logic                      ref_clk,          // 40 MHz clock
    input  wire logic                      reset_n,          // Synchronous reset, active low
    input  wire fls_pwr_pkg::pins_t        pins,             // Bus clock, select, reset pins
    input  wire fls_pwr_pkg::cmd_t         cmd,              // Decoded commands
    input  wire fls_pwr_pkg::xfer_t        xfer,             // Transfer data phase
    input  wire logic                      idle_standby,     // Array idle, no operation
    input  wire logic                      overlay_space_mode, // Overlay space selected
    output logic                           deep_sleep_mode,  // Lowest power state reached
    output logic                           sleep_entering,   // Entry window running
    output logic                           waking,           // Wake-up interval running
    output logic                           bus_accept,       // Commands may be served
    output logic                           cs_active,        // Qualified chip select
    output logic                           rwds_hold,        // Keep read strobe still
    output logic                           clock_stop,       // Clock stop low-current state
    output logic                           defaults_load,    // Config restored, pulse
    output logic [fls_pwr_pkg::CFG_W-1:0]  cfg_word,         // Live configuration
    output logic [fls_pwr_pkg::DQ_W-1:0]   dq_out,           // Latched read data
    output logic                           dq_oe             // Data bus driven
);
    import fls_pwr_pkg::*;

    localparam int TW = $clog2(WAKE_CYCLES + ENTRY_CYCLES + 1);
    localparam int SW = $clog2(STOP_CYCLES + 1);
    localparam int RW = $clog2(RST_CYCLES + 1);

    pwr_state_t       state_r, state_nxt;
    logic [2:0]       pin_s1_r, pin_s2_r;
    logic             ck_s3_r;
    logic [CFG_W-1:0] cfg_r;
    logic [SW-1:0]    still_cnt_r;
    logic [RW-1:0]    rst_cnt_r;
    logic             accept_r, hold_r, stop_r, dflt_r, cs_r, oe_r;
    logic [DQ_W-1:0]  dq_r;

    // Two flops on every pin; the second stage feeds logic, and a third flop on the clock pin feeds edge detect
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pin_s1_r <= 3'h3;
            pin_s2_r <= 3'h3;
            ck_s3_r  <= 1'b0;
        end else begin
            pin_s1_r <= {pins.ck, pins.cs_n, pins.hw_rst_n};
            pin_s2_r <= pin_s1_r;
            ck_s3_r  <= pin_s2_r[2];
        end
    end

    wire ck_s    = pin_s2_r[2];
    wire cs_n_s  = pin_s2_r[1];
    wire rst_n_s = pin_s2_r[0];
    wire ck_edge = ck_s ^ ck_s3_r;

    // Reset pulse width check: one event when the pulse reaches the minimum
    wire rst_event = !rst_n_s && (rst_cnt_r == RW'(RST_CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        if (!reset_n || rst_n_s)
            rst_cnt_r <= '0;
        else if (rst_cnt_r != RW'(RST_CYCLES))
            rst_cnt_r <= rst_cnt_r + RW'(1);
    end

    wire st_standby = (state_r == ST_STANDBY);
    wire st_entry   = (state_r == ST_ENTRY);
    wire st_sleep   = (state_r == ST_SLEEP);
    wire st_wake    = (state_r == ST_WAKE);

    // Entry request decode
    wire sleep_wr  = cmd.cfg_write && !cmd.cfg_data[SLEEP_BIT];
    wire entry_ok  = idle_standby && !overlay_space_mode;
    wire entry_go  = st_standby && accept_r && sleep_wr && entry_ok;
    wire wake_go   = (st_sleep && cmd.sleep_cmd) || (st_sleep && rst_event);
    wire abort_go  = st_entry && rst_event;
    wire t_done;

    // One timer serves both windows since they never overlap
    wire          t_start = entry_go || wake_go;
    wire [TW-1:0] t_len   = entry_go ? TW'(ENTRY_CYCLES) : TW'(WAKE_CYCLES);

    fls_interval_timer #(.W(TW)) u_timer (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .start   (t_start),
        .cancel  (abort_go),
        .length  (t_len),
        .busy    (),
        .done    (t_done)
    );

    // Sequencer; commands in the entry window are simply not looked at
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_STANDBY: begin
                if (entry_go)
                    state_nxt = ST_ENTRY;
            end
            ST_ENTRY: begin
                if (abort_go)
                    state_nxt = ST_STANDBY;
                else if (t_done)
                    state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_go)
                    state_nxt = ST_WAKE;
            end
            ST_WAKE: begin
                if (t_done)
                    state_nxt = ST_STANDBY;
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    wire restore = (st_wake && t_done) || abort_go;
    wire nxt_acc = (state_nxt == ST_STANDBY) && rst_n_s && !restore;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r  <= ST_STANDBY;
            accept_r <= 1'b0;
            hold_r   <= 1'b0;
            dflt_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            accept_r <= nxt_acc;
            hold_r   <= (state_nxt != ST_STANDBY);
            dflt_r   <= restore;
        end
    end

    // Config word; a refused sleep write leaves it unchanged
    wire cfg_take = st_standby && accept_r && cmd.cfg_write && (!sleep_wr || entry_ok);
    always_ff @(posedge ref_clk) begin
        if (!reset_n || restore)
            cfg_r <= CFG_DEFAULT;
        else if (cfg_take)
            cfg_r <= cmd.cfg_data;
    end

    // Chip select only counts while the bus is open
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            cs_r <= 1'b0;
        else
            cs_r <= nxt_acc && !cs_n_s;
    end

    // Still-clock counter; stop ends on the first edge, select may stay low
    wire in_xfer  = xfer.xfer_active && accept_r;
    wire stop_hit = in_xfer && !ck_edge && (still_cnt_r == SW'(STOP_CYCLES - 1));
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !in_xfer || ck_edge) begin
            still_cnt_r <= '0;
            stop_r      <= 1'b0;
        end else begin
            if (still_cnt_r != SW'(STOP_CYCLES))
                still_cnt_r <= still_cnt_r + SW'(1);
            if (stop_hit)
                stop_r <= 1'b1;
        end
    end

    // Read data latch frozen through clock stop
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dq_r <= '0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= in_xfer;
            if (xfer.read_valid && in_xfer && !stop_r && !stop_hit)
                dq_r <= xfer.read_data;
        end
    end

    assign deep_sleep_mode = state_r[2];
    assign sleep_entering  = state_r[1];
    assign waking          = state_r[3];
    assign bus_accept      = accept_r;
    assign cs_active       = cs_r;
    assign rwds_hold       = hold_r;
    assign clock_stop      = stop_r;
    assign defaults_load   = dflt_r;
    assign cfg_word        = cfg_r;
    assign dq_out          = dq_r;
    assign dq_oe           = oe_r;

    // Helper: length of the current entry window
    logic [TW-1:0] entry_len_r;
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !st_entry)
            entry_len_r <= '0;
        else
            entry_len_r <= entry_len_r + TW'(1);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wake_done;
        st_wake ##1 st_standby;
    endsequence

    sequence s_sleep_wr_refused;
        st_standby && cmd.cfg_write && !cmd.cfg_data[SLEEP_BIT] && !entry_ok;
    endsequence

    a_entry_refused: assert property (s_sleep_wr_refused |=> !st_entry)
        else $error("sleep entry taken outside idle standby");
    a_entry_min_len: assert property ($rose(st_sleep) |-> entry_len_r >= TW'(ENTRY_CYCLES - 1))
        else $error("deep sleep reached before the entry window");
    a_entry_deaf: assert property (st_entry |-> !accept_r && !cs_r)
        else $error("bus served during entry window");
    a_entry_no_abort: assert property (st_entry && cmd.sleep_cmd && !rst_event |=> st_entry || st_sleep)
        else $error("command disturbed sleep entry");
    a_cmd_exit: assert property (st_sleep && cmd.sleep_cmd |=> st_wake ##1 hold_r)
        else $error("sleep command did not start wake-up");
    a_wake_quiet: assert property (st_wake |-> hold_r && !accept_r ##1 !cs_r)
        else $error("bus served during wake-up");
    a_reset_exit: assert property (st_sleep && rst_event |=> st_wake)
        else $error("reset pulse did not leave deep sleep");
    a_reset_abort: assert property (st_entry && rst_event |=> st_standby && dflt_r)
        else $error("reset pulse did not abort entry");
    a_exit_defaults: assert property (s_wake_done |-> cfg_r == CFG_DEFAULT && dflt_r)
        else $error("defaults not restored on exit");
    a_stop_enter: assert property (stop_hit |=> stop_r)
        else $error("clock stop not entered");
    a_stop_hold: assert property (stop_r && $past(stop_r) |-> $stable(dq_r) && oe_r)
        else $error("read data not held in clock stop");
    a_stop_resume: assert property (stop_r && ck_edge |=> !stop_r)
        else $error("clock stop held after clock restart");
endmodule

//--- verif/fls_host_model.sv
// Host bus controller model driving the bus pins, decoded commands and read data
`timescale 1ns/1ps
module fls_host_model
    import fls_pwr_pkg::*;
(
    input  wire logic          ref_clk,  // System clock
    output fls_pwr_pkg::pins_t pins,     // Bus clock, select, reset pins
    output fls_pwr_pkg::cmd_t  cmd,      // Decoded commands
    output fls_pwr_pkg::xfer_t xfer      // Transfer data phase
);
    import fls_pwr_pkg::*;

    // Idle bus: clock parked low, deselected, reset pin released
    initial begin
        pins = '{ck: 1'b0, cs_n: 1'b1, hw_rst_n: 1'b1};
        cmd  = '0;
        xfer = '0;
    end

    // Every task starts at a falling edge and returns at one
    task automatic cfg_wr(input logic [15:0] d);
        cmd.cfg_write = 1'b1;
        cmd.cfg_data  = d;
        @(negedge ref_clk);
        cmd.cfg_write = 1'b0;
        cmd.cfg_data  = ~d;  // Stale data is never left on the lines
    endtask

    task automatic sleep_pulse();
        cmd.sleep_cmd = 1'b1;
        @(negedge ref_clk);
        cmd.sleep_cmd = 1'b0;
    endtask

    task automatic rst_pulse(input int cyc);
        pins.hw_rst_n = 1'b0;
        repeat (cyc) @(negedge ref_clk);
        pins.hw_rst_n = 1'b1;
    endtask

    task automatic select(input logic on);
        pins.cs_n        = ~on;
        xfer.xfer_active = on;
    endtask

    // One clock pulse per beat; reads only, never during a register access
    task automatic read_beat(input logic [7:0] d);
        pins.ck         = 1'b1;
        xfer.read_valid = 1'b1;
        xfer.read_data  = d;
        @(negedge ref_clk);
        pins.ck         = 1'b0;  // Clock always parked in its low state
        xfer.read_valid = 1'b0;
        xfer.read_data  = ~d;
        @(negedge ref_clk);
    endtask
endmodule

//--- verif/tb_fls_pwr_ctrl.sv
// Self-checking bench for the flash power-saving control
`timescale 1ns/1ps
module tb_fls_pwr_ctrl;
    import fls_pwr_pkg::*;

    // Short counts keep the run brief; entry outlasts a reset abort
    localparam int E = 40;
    localparam int W = 20;
    localparam int S = 6;
    localparam int R = 8;

    logic               ref_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               idle_standby;
    logic               overlay_space_mode;
    pins_t              pins;
    cmd_t               cmd;
    xfer_t              xfer;
    logic               deep_sleep_mode, sleep_entering, waking, bus_accept, cs_active;
    logic               rwds_hold, clock_stop, defaults_load, dq_oe;
    logic [CFG_W-1:0]   cfg_word;
    logic [DQ_W-1:0]    dq_out;
    int                 failures = 0;
    int                 samples_checked = 0;

    always #12.5 ref_clk = ~ref_clk;

    fls_host_model u_fls_host_model (.ref_clk(ref_clk), .pins(pins), .cmd(cmd), .xfer(xfer));

    fls_pwr_ctrl #(.ENTRY_CYCLES(E), .WAKE_CYCLES(W), .STOP_CYCLES(S), .RST_CYCLES(R)) u_fls_pwr_ctrl (
        .ref_clk(ref_clk), .reset_n(reset_n), .pins(pins), .cmd(cmd), .xfer(xfer),
        .idle_standby(idle_standby), .overlay_space_mode(overlay_space_mode),
        .deep_sleep_mode(deep_sleep_mode), .sleep_entering(sleep_entering), .waking(waking),
        .bus_accept(bus_accept), .cs_active(cs_active), .rwds_hold(rwds_hold), .clock_stop(clock_stop),
        .defaults_load(defaults_load), .cfg_word(cfg_word), .dq_out(dq_out), .dq_oe(dq_oe));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    // A wait that ran out of cycles ends the run at once
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            chk(1'b0, "wait bound exhausted");
            print_verdict();
        end
    endtask

    task automatic t_entry_exit();
        int n;
        u_fls_host_model.cfg_wr(16'hBEEF);
        @(negedge ref_clk);
        chk(cfg_word === 16'hBEEF && bus_accept === 1'b1, "plain config write");
        idle_standby = 1'b0;
        u_fls_host_model.cfg_wr(16'h7EEF);
        @(negedge ref_clk);
        chk(sleep_entering === 1'b0 && cfg_word === 16'hBEEF, "entry while busy");
        idle_standby = 1'b1;
        overlay_space_mode = 1'b1;
        u_fls_host_model.cfg_wr(16'h7EEF);
        @(negedge ref_clk);
        chk(sleep_entering === 1'b0 && cfg_word === 16'hBEEF, "entry in overlay");
        overlay_space_mode = 1'b0;
        u_fls_host_model.cfg_wr(16'h7EEF);
        @(negedge ref_clk);
        chk(sleep_entering === 1'b1 && bus_accept === 1'b0 && rwds_hold === 1'b1, "entry start");
        u_fls_host_model.select(1'b1);
        u_fls_host_model.sleep_pulse();
        // Let the select pin cross the synchroniser before judging it
        repeat (3) @(negedge ref_clk);
        chk(cs_active === 1'b0 && sleep_entering === 1'b1, "entry disturbed");
        u_fls_host_model.select(1'b0);
        for (n = 5; deep_sleep_mode !== 1'b1 && n < E + 20; n++) @(negedge ref_clk);
        hang(n, E + 20);
        chk(n === E, "entry window length");
        // Exit only once the whole entry window is behind us
        u_fls_host_model.sleep_pulse();
        @(negedge ref_clk);
        chk(waking === 1'b1 && rwds_hold === 1'b1 && bus_accept === 1'b0, "wake start");
        u_fls_host_model.sleep_pulse();
        u_fls_host_model.cfg_wr(16'h1234);
        chk(waking === 1'b1 && cfg_word !== 16'h1234, "command during wake");
        for (n = 3; waking === 1'b1 && n < W + 20; n++) @(negedge ref_clk);
        hang(n, W + 20);
        chk(n === W && defaults_load === 1'b1 && bus_accept === 1'b0, "wake length");
        chk(cfg_word === CFG_DEFAULT && deep_sleep_mode === 1'b0, "defaults after exit");
        // Bus opens one cycle after the restore, so the next write is not lost
        @(negedge ref_clk);
        chk(bus_accept === 1'b1 && defaults_load === 1'b0, "bus open after wake");
        $display("test entry_exit done");
    endtask

    task automatic t_reset_abort();
        int n;
        u_fls_host_model.cfg_wr(16'h7EEF);
        u_fls_host_model.rst_pulse(R + 2);
        for (n = 0; sleep_entering === 1'b1 && n < 10; n++) @(negedge ref_clk);
        hang(n, 10);
        chk(deep_sleep_mode === 1'b0 && waking === 1'b0, "entry not aborted");
        for (n = 0; bus_accept !== 1'b1 && n < 10; n++) @(negedge ref_clk);
        hang(n, 10);
        $display("test reset_abort done");
    endtask

    task automatic t_reset_exit();
        int n;
        u_fls_host_model.cfg_wr(16'hBEEF);
        @(negedge ref_clk);
        u_fls_host_model.cfg_wr(16'h7EEF);
        for (n = 0; deep_sleep_mode !== 1'b1 && n < E + 20; n++) @(negedge ref_clk);
        hang(n, E + 20);
        u_fls_host_model.rst_pulse(R + 2);
        for (n = 0; waking !== 1'b1 && n < 8; n++) @(negedge ref_clk);
        hang(n, 8);
        for (n = 0; waking === 1'b1 && n < W + 8; n++) @(negedge ref_clk);
        hang(n, W + 8);
        chk(n === W && defaults_load === 1'b1 && bus_accept === 1'b0, "reset exit standby");
        chk(cfg_word === CFG_DEFAULT, "defaults after reset exit");
        @(negedge ref_clk);
        chk(bus_accept === 1'b1, "bus open after reset exit");
        $display("test reset_exit done");
    endtask

    task automatic t_clock_stop();
        int n;
        u_fls_host_model.select(1'b1);
        u_fls_host_model.read_beat(8'h3C);
        u_fls_host_model.read_beat(8'hA5);
        for (n = 0; clock_stop !== 1'b1 && n < S + 10; n++) @(negedge ref_clk);
        hang(n, S + 10);
        chk(n >= S && n <= S + 4 && cs_active === 1'b1, "still time before stop");
        repeat (4) @(negedge ref_clk);
        chk(clock_stop === 1'b1 && dq_out === 8'hA5 && dq_oe === 1'b1, "data held in stop");
        // First beat only restarts the clock; the latch stays frozen until stop clears
        u_fls_host_model.read_beat(8'h96);
        for (n = 2; clock_stop === 1'b1 && n < 8; n++) @(negedge ref_clk);
        hang(n, 8);
        chk(n < 8 && dq_out === 8'hA5, "resume after stop");
        u_fls_host_model.read_beat(8'h69);
        chk(clock_stop === 1'b0 && dq_out === 8'h69, "read after resume");
        u_fls_host_model.select(1'b0);
        $display("test clock_stop done");
    endtask

    initial begin
        idle_standby       = 1'b1;
        overlay_space_mode = 1'b0;
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_entry_exit();
        t_reset_abort();
        t_reset_exit();
        t_clock_stop();
        print_verdict();
    end
endmodule
